// File: src/pms_top.sv
// MAC-side pins: transmit capture, collision, carrier, indicators, reset.
`timescale 1ns/1ps
`default_nettype none


// Dual-clock FIFO with gray pointers and registered read output.
module pms_afifo #(
    parameter int unsigned W = 5,
    parameter int unsigned D = 32
) (
    // Write side.
    input  wire logic         i_wclk,
    input  wire logic         i_wrst,
    input  wire logic         i_wvalid,
    input  wire logic [W-1:0] i_wdata,
    output logic              o_wready,
    // Read side.
    input  wire logic         i_rclk,
    input  wire logic         i_rrst,
    output logic              o_rvalid,
    output logic [W-1:0]      o_rdata,
    input  wire logic         i_rready
);
    localparam int unsigned AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wbin_r;
    logic [AW:0]  wgray_r;
    logic [AW:0]  rbin_r;
    logic [AW:0]  rgray_r;
    logic [AW:0]  rg_s1_r;
    logic [AW:0]  rg_s2_r;
    logic [AW:0]  wg_s1_r;
    logic [AW:0]  wg_s2_r;
    logic [AW:0]  wbin_nxt;
    logic [AW:0]  rbin_nxt;
    logic         full;
    logic         empty;
    logic         do_wr;
    logic         do_rd;

    // Full compares against the read pointer seen in the write domain.
    assign full  = (wgray_r == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
    assign empty = (rgray_r == wg_s2_r);
    assign o_wready = ~full;
    assign do_wr = i_wvalid & ~full;
    assign do_rd = ~empty & (~o_rvalid | i_rready);
    assign wbin_nxt = wbin_r + 1'b1;
    assign rbin_nxt = rbin_r + 1'b1;

    // Write pointer and storage.
    always_ff @(posedge i_wclk) begin
        if (i_wrst) begin
            wbin_r  <= '0;
            wgray_r <= '0;
        end else if (do_wr) begin
            wbin_r  <= wbin_nxt;
            wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
        end
    end

    always_ff @(posedge i_wclk) begin
        if (do_wr) begin
            mem[wbin_r[AW-1:0]] <= i_wdata;
        end
    end

    // Read pointer seen from the write side.
    always_ff @(posedge i_wclk) begin
        if (i_wrst) begin
            rg_s1_r <= '0;
            rg_s2_r <= '0;
        end else begin
            rg_s1_r <= rgray_r;
            rg_s2_r <= rg_s1_r;
        end
    end

    // Write pointer seen from the read side.
    always_ff @(posedge i_rclk) begin
        if (i_rrst) begin
            wg_s1_r <= '0;
            wg_s2_r <= '0;
        end else begin
            wg_s1_r <= wgray_r;
            wg_s2_r <= wg_s1_r;
        end
    end

    // Read pointer and output register.
    always_ff @(posedge i_rclk) begin
        if (i_rrst) begin
            rbin_r   <= '0;
            rgray_r  <= '0;
            o_rvalid <= 1'b0;
            o_rdata  <= '0;
        end else if (do_rd) begin
            rbin_r   <= rbin_nxt;
            rgray_r  <= rbin_nxt ^ (rbin_nxt >> 1);
            o_rvalid <= 1'b1;
            o_rdata  <= mem[rbin_r[AW-1:0]];
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end
endmodule

// Top of the MAC-side pin logic.
module pms_top
    import pms_pkg::*;
#(
    parameter int unsigned BLINK_HALF = BLINK_CYC
) (
    // System clock and reset.
    input  wire logic               i_mclk,
    input  wire logic               i_srst,
    // Hardware reset pin and strap pin levels.
    input  wire logic               i_rst_pin_n,
    input  wire logic [STRAP_N-1:0] i_strap,
    // Link clock and transmit pins from the MAC.
    input  wire logic               i_link_clk,
    input  wire logic               i_tx_en,
    input  wire logic [TXD_W-1:0]   i_txd,
    // Status from the media core.
    input  wire logic               i_link_up,
    input  wire logic               i_speed_100,
    input  wire logic               i_full_duplex,
    input  wire logic               i_rx_active,
    input  wire logic               i_speed_pin_as_txer,
    // Transmit stream to the media core.
    output logic                    o_txq_valid,
    output pms_txw_t                o_txq_data,
    input  wire logic               i_txq_ready,
    output logic                    o_txq_overflow,
    // Collision and carrier pins.
    output logic                    o_col,
    output logic                    o_col_oe_n,
    output logic                    o_crs,
    output logic                    o_crs_oe_n,
    // Indicator pins; the speed pin is two-way.
    output logic                    o_link_activity_indicator_n,
    output logic                    o_link_activity_indicator_oe_n,
    output logic                    o_speed_indicator_n,
    output logic                    o_speed_indicator_oe_n,
    input  wire logic               i_speed_indicator,
    // Reset state and latched straps.
    output logic                    o_in_reset,
    output logic [STRAP_N-1:0]      o_straps
);
    logic                 prst_s1_r;
    logic                 prst_s2_r;
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic                 hw_rst_r;
    logic [STRAP_N-1:0]   strap_s1_r;
    logic [STRAP_N-1:0]   strap_s2_r;
    logic                 rmii;
    logic                 txa_s1_r;
    logic                 txa_s2_r;
    logic                 ovf_s1_r;
    logic                 ovf_s2_r;
    logic [BLINK_W-1:0]   blink_cnt_r;
    logic                 blink_ph_r;
    logic                 act_acc_r;
    logic                 act_win_r;
    logic                 activity;
    // Link-domain signals.
    logic                 lrst_s1_r;
    logic                 lrst_s2_r;
    logic                 lmode_s1_r;
    logic                 lmode_s2_r;
    logic                 lsel_s1_r;
    logic                 lsel_s2_r;
    logic                 ltx_en_r;
    logic                 lphase_r;
    logic [1:0]           llo_r;
    logic                 ller_r;
    logic                 lwvalid_r;
    pms_txw_t             lwdata_r;
    logic                 lwready;
    logic                 lovf_r;
    logic                 ltx_er;

    // Reset pin passes two flip-flops before the duration check.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            prst_s1_r <= 1'b1;
            prst_s2_r <= 1'b1;
        end else begin
            prst_s1_r <= i_rst_pin_n;
            prst_s2_r <= prst_s1_r;
        end
    end

    // Reset starts once the pin has been low long enough.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rst_cnt_r <= '0;
            hw_rst_r  <= 1'b0;
        end else if (prst_s2_r) begin
            rst_cnt_r <= '0;
            hw_rst_r  <= 1'b0;
        end else if (rst_cnt_r == RST_CNT_W'(RST_MIN_CYC - 1)) begin
            hw_rst_r  <= 1'b1;
        end else begin
            rst_cnt_r <= rst_cnt_r + 1'b1;
        end
    end

    // Combined internal reset, held high through system reset.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_in_reset <= 1'b1;
        end else begin
            o_in_reset <= hw_rst_r;
        end
    end

    // Strap levels are synchronised and latched while reset is active.
    always_ff @(posedge i_mclk) begin
        strap_s1_r <= i_strap;
        strap_s2_r <= strap_s1_r;
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_straps <= STRAP_RST;
        end else if (o_in_reset) begin
            o_straps <= strap_s2_r;
        end
    end

    assign rmii = o_straps[STRAP_RMII];

    // Transmit activity and overflow cross into the system domain.
    always_ff @(posedge i_mclk) begin
        if (o_in_reset) begin
            txa_s1_r <= 1'b0;
            txa_s2_r <= 1'b0;
            ovf_s1_r <= 1'b0;
            ovf_s2_r <= 1'b0;
        end else begin
            txa_s1_r <= ltx_en_r;
            txa_s2_r <= txa_s1_r;
            ovf_s1_r <= lovf_r;
            ovf_s2_r <= ovf_s1_r;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (o_in_reset) begin
            o_txq_overflow <= 1'b0;
        end else begin
            o_txq_overflow <= ovf_s2_r;
        end
    end

    // Collision and carrier follow medium activity in MII mode only.
    always_ff @(posedge i_mclk) begin
        if (o_in_reset) begin
            o_col      <= 1'b0;
            o_crs      <= 1'b0;
            o_col_oe_n <= 1'b1;
            o_crs_oe_n <= 1'b1;
        end else begin
            o_col <= ~rmii & ~i_full_duplex & txa_s2_r & i_rx_active;
            o_crs <= ~rmii & (txa_s2_r | i_rx_active);
            o_col_oe_n <= rmii;
            o_crs_oe_n <= rmii;
        end
    end

    assign activity = txa_s2_r | i_rx_active;

    // Blink timer; activity seen in one period blinks the next.
    always_ff @(posedge i_mclk) begin
        if (o_in_reset) begin
            blink_cnt_r <= '0;
            blink_ph_r  <= 1'b0;
            act_acc_r   <= 1'b0;
            act_win_r   <= 1'b0;
        end else if (blink_cnt_r == BLINK_W'(BLINK_HALF - 1)) begin
            blink_cnt_r <= '0;
            blink_ph_r  <= ~blink_ph_r;
            act_acc_r   <= activity;
            act_win_r   <= act_acc_r | activity;
        end else begin
            blink_cnt_r <= blink_cnt_r + 1'b1;
            act_acc_r   <= act_acc_r | activity;
        end
    end

    // Indicators are active low; pins stay inputs during reset.
    always_ff @(posedge i_mclk) begin
        if (o_in_reset) begin
            o_link_activity_indicator_n    <= 1'b1;
            o_link_activity_indicator_oe_n <= 1'b1;
            o_speed_indicator_n            <= 1'b1;
            o_speed_indicator_oe_n         <= 1'b1;
        end else begin
            o_link_activity_indicator_n <=
                ~(i_link_up & ~(act_win_r & blink_ph_r));
            o_link_activity_indicator_oe_n <= 1'b0;
            o_speed_indicator_n <= ~(i_link_up & i_speed_100);
            o_speed_indicator_oe_n <= i_speed_pin_as_txer;
        end
    end

    // Reset, mode and pin function cross into the link domain.
    always_ff @(posedge i_link_clk) begin
        lrst_s1_r  <= o_in_reset;
        lrst_s2_r  <= lrst_s1_r;
        lmode_s1_r <= rmii;
        lmode_s2_r <= lmode_s1_r;
        lsel_s1_r  <= i_speed_pin_as_txer;
        lsel_s2_r  <= lsel_s1_r;
    end

    // The error input exists only once the speed pin is repurposed.
    assign ltx_er = lsel_s2_r & i_speed_indicator;

    // Capture the MAC pins on the rising link clock edge.
    always_ff @(posedge i_link_clk) begin
        if (lrst_s2_r) begin
            ltx_en_r  <= 1'b0;
            lphase_r  <= 1'b0;
            llo_r     <= 2'h0;
            ller_r    <= 1'b0;
            lwvalid_r <= 1'b0;
            lwdata_r  <= '0;
        end else begin
            ltx_en_r  <= i_tx_en;
            lwvalid_r <= 1'b0;
            if (!i_tx_en) begin
                lphase_r <= 1'b0;
            end else if (!lmode_s2_r) begin
                lwvalid_r <= 1'b1;
                lwdata_r  <= '{er: ltx_er, nib: i_txd};
            end else if (!lphase_r) begin
                lphase_r <= 1'b1;
                llo_r    <= i_txd[1:0];
                ller_r   <= ltx_er;
            end else begin
                lphase_r  <= 1'b0;
                lwvalid_r <= 1'b1;
                lwdata_r  <= '{er: ltx_er | ller_r,
                               nib: {i_txd[1:0], llo_r}};
            end
        end
    end

    // A word the full buffer cannot take is lost and flagged.
    always_ff @(posedge i_link_clk) begin
        if (lrst_s2_r) begin
            lovf_r <= 1'b0;
        end else if (lwvalid_r && !lwready) begin
            lovf_r <= 1'b1;
        end
    end

    // Transmit buffer between the link and system domains.
    pms_afifo #(
        .W (TXW_W),
        .D (TXQ_DEPTH)
    ) u_txq (
        .i_wclk   (i_link_clk),
        .i_wrst   (lrst_s2_r),
        .i_wvalid (lwvalid_r),
        .i_wdata  (lwdata_r),
        .o_wready (lwready),
        .i_rclk   (i_mclk),
        .i_rrst   (o_in_reset),
        .o_rvalid (o_txq_valid),
        .o_rdata  (o_txq_data),
        .i_rready (i_txq_ready)
    );
endmodule
`default_nettype wire

// File: src/pms_pkg.sv
// Shared constants and types for the MAC-side pin block.
`default_nettype none
package pms_pkg;
    // System clock period and derived timing counts.
    localparam int unsigned CLK_NS      = 25;
    localparam int unsigned RST_MIN_NS  = 25000;
    localparam int unsigned RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned BLINK_NS    = 20000000;
    localparam int unsigned BLINK_CYC   = BLINK_NS / CLK_NS;
    localparam int unsigned RST_CNT_W   = 11;
    localparam int unsigned BLINK_W     = 20;

    // Strap pins and the strap that selects the reduced interface.
    localparam int unsigned STRAP_N      = 11;
    localparam int unsigned STRAP_RMII   = 4;
    localparam logic [10:0] STRAP_RST    = 11'h000;

    // Transmit buffer shape.
    localparam int unsigned TXQ_DEPTH = 32;
    localparam int unsigned TXD_W     = 4;

    // One transmit nibble with its error mark.
    typedef struct packed {
        logic             er;
        logic [TXD_W-1:0] nib;
    } pms_txw_t;

    localparam int unsigned TXW_W = $bits(pms_txw_t);
endpackage
`default_nettype wire

// File: verif/pms_mac_model.sv
// Behavioural transmit side of the MAC driving the link pins.
`timescale 1ns/1ps
`default_nettype none
module pms_mac_model (
    // Link clock and interface mode.
    input  wire logic i_clk,
    input  wire logic i_rmii,
    // Transmit pins.
    output logic       o_tx_en,
    output logic [3:0] o_txd,
    output logic       o_txer
);
    // Pins start idle.
    initial begin
        o_tx_en = 1'b0;
        o_txd   = 4'h5;
        o_txer  = 1'b0;
    end
    // Sends one nibble; the reduced mode sends the low dibit first.
    task automatic send(input logic [3:0] n, input logic e);
        @(posedge i_clk);
        o_tx_en <= 1'b1;
        o_txer  <= e;
        if (i_rmii) begin
            o_txd <= {~o_txd[3:2], n[1:0]};
            @(posedge i_clk);
            o_txd <= {~o_txd[3:2], n[3:2]};
        end else begin
            o_txd <= n;
        end
    endtask
    // Released lines toggle so a stale level never looks valid.
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_tx_en <= 1'b0;
            o_txd   <= ~o_txd;
            o_txer  <= ~o_txer;
        end
    endtask
endmodule
`default_nettype wire

// File: verif/pms_top_monitor.sv
// Port checker for the MAC-side pin block.
`timescale 1ns/1ps
`default_nettype none
module pms_top_monitor
    import pms_pkg::*;
#(
    parameter int unsigned BLINK_HALF = 8
) (
    // Clock, reset and inputs.
    input wire logic               i_mclk,
    input wire logic               i_srst,
    input wire logic               i_rst_pin_n,
    input wire logic               i_link_up,
    input wire logic               i_speed_100,
    input wire logic               i_full_duplex,
    input wire logic               i_rx_active,
    input wire logic               i_speed_pin_as_txer,
    // Outputs under watch.
    input wire logic               o_txq_valid,
    input wire logic               o_col,
    input wire logic               o_col_oe_n,
    input wire logic               o_crs,
    input wire logic               o_link_activity_indicator_n,
    input wire logic               o_speed_indicator_n,
    input wire logic               o_speed_indicator_oe_n,
    input wire logic               o_in_reset,
    input wire logic [STRAP_N-1:0] o_straps
);
    logic [10:0] low_r;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // Counts consecutive low cycles of the raw reset pin, saturating.
    always_ff @(posedge i_mclk) begin
        if (i_rst_pin_n) begin
            low_r <= 11'h000;
        end else if (low_r != 11'h7ff) begin
            low_r <= low_r + 11'h001;
        end
    end
    a_col_full_low: assert property (i_full_duplex [*2] |-> !o_col)
        else $error("collision in full duplex");
    a_col_both_busy: assert property (
        o_col |-> !$past(i_full_duplex) && $past(i_rx_active))
        else $error("collision without cause");
    a_rmii_col_off: assert property (
        o_straps[STRAP_RMII] && !o_in_reset |-> o_col_oe_n && !o_col)
        else $error("collision pin used in reduced mode");
    a_crs_on_rx: assert property (
        !o_in_reset && !o_straps[STRAP_RMII] && i_rx_active
        |=> o_crs || o_in_reset)
        else $error("carrier missing");
    a_link_led_off: assert property (
        !i_link_up [*2] |-> o_link_activity_indicator_n)
        else $error("link indicator lit without link");
    a_speed_led: assert property (
        !i_speed_pin_as_txer && !o_in_reset |=> o_in_reset ||
        (!o_speed_indicator_oe_n && o_speed_indicator_n ==
         !($past(i_link_up) && $past(i_speed_100))))
        else $error("speed indicator wrong");
    a_txer_tristate: assert property (
        i_speed_pin_as_txer [*2] |-> o_speed_indicator_oe_n)
        else $error("speed pin driven in error-input mode");
    a_pin_reset_len: assert property (
        $rose(o_in_reset) && !$past(i_srst) |-> low_r >= 11'h3e8)
        else $error("reset from short pin pulse");
    a_reset_quiet: assert property (
        o_in_reset [*2] |-> o_col_oe_n && !o_txq_valid)
        else $error("outputs active in reset");
    a_straps_held: assert property (
        !o_in_reset [*2] |-> $stable(o_straps))
        else $error("straps moved outside reset");
    c_col: cover property (o_col);
    c_pin_reset: cover property ($rose(o_in_reset) && !$past(i_srst));
    c_blink: cover property (i_link_up && $rose(o_link_activity_indicator_n));
endmodule
bind pms_top pms_top_monitor #(.BLINK_HALF(BLINK_HALF)) u_mon (
    .i_mclk, .i_srst, .i_rst_pin_n, .i_link_up, .i_speed_100,
    .i_full_duplex, .i_rx_active, .i_speed_pin_as_txer, .o_txq_valid,
    .o_col, .o_col_oe_n, .o_crs, .o_link_activity_indicator_n,
    .o_speed_indicator_n, .o_speed_indicator_oe_n, .o_in_reset, .o_straps
);
`default_nettype wire

// File: verif/tb_pms_top.sv
// Self-checking bench for the MAC-side pin block.
`timescale 1ns/1ps
`default_nettype none
module tb_pms_top
    import pms_pkg::*;
;
    logic               mclk = 1'b0, lclk = 1'b0, srst, pin_n, rmii;
    logic [STRAP_N-1:0] strap, lat, straps;
    logic               lnk, s100, fdx, rxa, txer_m, ready, rdy_en;
    logic               tx_en, txer, spd_pin, vld, ovf, col, col_oe_n;
    logic               crs, crs_oe_n, led_n, spd_n, spd_oe_n, in_rst;
    logic               led_oe_n;
    logic               col_seen, rst_seen, last;
    logic [3:0]         txd;
    pms_txw_t           qdata;
    logic [4:0]         q[$];
    int                 miscompares = 0, cmp_count = 0, cycles = 0;
    int                 got, tog;

    // System clock of 25 ns.
    always #12.5 mclk = ~mclk;
    // Link clock of 6 ns, offset in phase.
    initial begin
        #1.7;
        forever #3 lclk = ~lclk;
    end
    // Two-way speed pin: the design's level while driven, else the MAC's.
    assign spd_pin = spd_oe_n ? txer : spd_n;

    pms_top #(.BLINK_HALF(8)) DUT (
        .i_mclk(mclk), .i_srst(srst), .i_rst_pin_n(pin_n), .i_strap(strap),
        .i_link_clk(lclk), .i_tx_en(tx_en), .i_txd(txd), .i_link_up(lnk),
        .i_speed_100(s100), .i_full_duplex(fdx), .i_rx_active(rxa),
        .i_speed_pin_as_txer(txer_m), .o_txq_valid(vld), .o_txq_data(qdata),
        .i_txq_ready(ready), .o_txq_overflow(ovf), .o_col(col),
        .o_col_oe_n(col_oe_n), .o_crs(crs), .o_crs_oe_n(crs_oe_n),
        .o_link_activity_indicator_n(led_n),
        .o_link_activity_indicator_oe_n(led_oe_n),
        .o_speed_indicator_n(spd_n),
        .o_speed_indicator_oe_n(spd_oe_n), .i_speed_indicator(spd_pin),
        .o_in_reset(in_rst), .o_straps(straps)
    );
    pms_mac_model mac (
        .i_clk(lclk), .i_rmii(rmii), .o_tx_en(tx_en), .o_txd(txd),
        .o_txer(txer)
    );

    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Random status, checked after the one-cycle output latency.
    task automatic step(input int n);
        repeat (n) begin
            @(posedge mclk);
            lnk  <= 1'($urandom);
            s100 <= 1'($urandom);
            fdx  <= 1'($urandom);
            rxa  <= 1'($urandom);
            @(posedge mclk);
            @(negedge mclk);
            chk(spd_n, !(lnk && s100));
            chk(crs, rxa);
            chk(col, 1'b0);
        end
    endtask
    // Sends a frame of random nibbles and queues what should come out.
    task automatic frame(input int n, input logic er_on);
        logic [3:0] nib;
        logic       e;
        for (int i = 0; i < n; i++) begin
            nib = 4'($urandom);
            e   = er_on & ($urandom_range(3) == 0);
            q.push_back({e, nib});
            mac.send(nib, e);
        end
        mac.idle(4);
        for (int k = 0; k < 400 && (vld || k < 20); k++) @(posedge mclk);
    endtask
    // Consumer with random stalls, order check, hang limit.
    always @(posedge mclk) begin
        cycles++;
        if (vld && ready) begin
            chk(qdata, q.size() ? q.pop_front() : 5'h1f);
            got++;
        end
        col_seen |= col;
        rst_seen |= in_rst;
        ready <= rdy_en & ($urandom_range(3) != 0);
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    // Main sequence.
    initial begin
        void'($urandom(85715));
        srst  = 1'b1;
        pin_n = 1'b1;
        strap = 11'($urandom) & 11'h7ef;
        {lnk, s100, fdx, rxa, txer_m, rdy_en, rmii} = 7'h00;
        {col_seen, rst_seen, got, tog} = '0;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        repeat (5) @(posedge mclk);
        chk(straps, strap);
        step(40);
        @(posedge mclk);
        lnk <= 1'b1;
        rxa <= 1'b1;
        @(negedge mclk);
        last = led_n;
        repeat (48) @(negedge mclk) begin
            tog += int'(led_n !== last);
            last = led_n;
        end
        chk(tog >= 3, 1'b1);
        @(posedge mclk);
        rxa <= 1'b0;
        repeat (40) @(posedge mclk);
        chk(led_n, 1'b0);
        chk(led_oe_n, 1'b0);
        txer_m <= 1'b1;
        fdx    <= 1'b0;
        rdy_en <= 1'b1;
        rxa    <= 1'b1;
        col_seen = 1'b0;
        repeat (4) @(posedge mclk);
        frame(24, 1'b1);
        chk(col_seen, 1'b1);
        chk(q.size(), 0);
        chk(spd_oe_n, 1'b1);
        txer_m <= 1'b0;
        fdx    <= 1'b1;
        rdy_en <= 1'b0;
        repeat (4) @(posedge mclk);
        col_seen = 1'b0;
        frame(40, 1'b0);
        chk(col_seen, 1'b0);
        chk(ovf, 1'b1);
        got = 0;
        rdy_en <= 1'b1;
        frame(0, 1'b0);
        chk(got >= TXQ_DEPTH, 1'b1);
        q.delete();
        rst_seen = 1'b0;
        pin_n <= 1'b0;
        repeat (500) @(posedge mclk);
        pin_n <= 1'b1;
        repeat (10) @(posedge mclk);
        chk(rst_seen, 1'b0);
        lat = 11'($urandom) | 11'h010;
        strap <= lat;
        pin_n <= 1'b0;
        repeat (1100) @(posedge mclk);
        pin_n <= 1'b1;
        repeat (12) @(posedge mclk);
        strap <= ~lat;
        repeat (4) @(posedge mclk);
        chk(rst_seen, 1'b1);
        chk(straps, lat);
        chk(ovf, 1'b0);
        rmii = 1'b1;
        fdx <= 1'b0;
        frame(10, 1'b0);
        chk(q.size(), 0);
        chk({col_seen, col_oe_n, crs_oe_n}, 3'h3);
        final_report();
    end
endmodule
`default_nettype wire
